// ### rstc_pkg.sv
// Constants, types and field layout of the system reset controller
// How it works
// R1: After supply is good, hold reset until the power-on delay counter expires.
// R2: Crystal option selects a longer power-on delay than without it.
// R3: Watchdog time-out resets the system only when configured for reset.
// R4: Outside stop, pin lows shorter than four clocks are ignored.
// R5: In stop, pin lows narrower than 12 ns are discarded, wider ones reset; the code resets only on lows seen at two clock edges in a row.
// R6: Pin reset during stop sets the pin-reset cause flag.
// R7: Debugger control bit 0 resets everything except the on-chip debugger.
// R8: On leaving reset the CPU is told to fetch the reset vector.
// R9: Completed power-on reset leaves the power-on cause flag at 1.
// R10: Debug line low for nine bit times raises a debug reset.
// R11: Stop bit sampled low raises a debug reset.
// R12: Collision on the debug line raises a debug reset; host must not overlap.
// R13: Debug reset in stop resets all logic except the on-chip debugger.
// R14: Debug reset in stop sets the power-on cause flag.
// R15: Cause status is read-only and shows the latest reset or time-out source.
// R16: Reading cause status clears its upper four bits, lower bits unchanged.
// R17: Pin filter counts consecutive lows, saturates, clears on any high sample.
// R18: Cause status address is shared; writes go to watchdog unlock logic.
package rstc_pkg;
    // ----------------------------------------------------------------
    // Register map, 8-bit data
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CAUSE = 8'h00;
    localparam logic [7:0] ADDR_DBGCTL = 8'h01;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h02;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h03;
    // Cause status fields
    localparam int CAUSE_POR = 7;
    localparam int CAUSE_STOP = 6;
    localparam int CAUSE_WDT = 5;
    localparam int CAUSE_PIN = 4;
    localparam int CAUSE_DBGCTL = 3;
    localparam int CAUSE_DBGLINE = 2;
    localparam int DBGCTL_RESET = 0;
    // Interrupt status and mask fields
    localparam int IRQ_BREAK = 0;
    localparam int IRQ_FRAME = 1;
    localparam int IRQ_COLL = 2;
    localparam int IRQ_WDT = 3;
    localparam logic [3:0] IRQ_W1C_MASK = 4'hf;
    // Reset values
    localparam logic [7:0] CAUSE_RST = 8'h00;
    localparam logic [7:0] POR_DONE_CAUSE = 8'h80;
    localparam logic [3:0] IRQ_RST = 4'h0;
    localparam logic [2:0] SYNC_RST = 3'b110;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 25000;
    localparam logic [2:0] PIN_FILT_CYC = 3'h4;
    localparam int STOP_FILT_NS = 12;
    localparam int STOP_FILT_CALC = (STOP_FILT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [2:0] STOP_FILT_CYC = (STOP_FILT_CALC < 1) ? 3'h1 : 3'(STOP_FILT_CALC);
    localparam int BREAK_BITS = 9;
    localparam logic [3:0] STOP_IDX = 4'h9;
    // ----------------------------------------------------------------
    // Sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        RSTC_POR = 2'b00,
        RSTC_HOLD = 2'b01,
        RSTC_RUN = 2'b10
    } rstc_state_t;
endpackage

// ### rstc_top.sv
// System reset controller: sources, filters, debug-line checks, cause status
`timescale 1ns/1ps
module rstc_top import rstc_pkg::*; #(
    parameter int POR_SHORT_CYC = 64,
    parameter int POR_LONG_CYC = 1024,
    parameter int HOLD_CYC = 16,
    parameter int BIT_CYC = 16
) (
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic power_good_i,
    input wire logic xtal_en_i,
    input wire logic stop_mode_i,
    input wire logic pin_reset_n_i,
    input wire logic debug_line_i,
    input wire logic dbg_tx_en_i,
    input wire logic dbg_tx_bit_i,
    input wire logic wdt_timeout_i,
    input wire logic wdt_reset_mode_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic we_i,
    input wire logic re_i,
    output logic [7:0] rdata_o,
    output logic sys_rst_n_o,
    output logic ocd_rst_n_o,
    output logic fetch_vector_o,
    output logic debug_reset_o,
    output logic wdt_ctl_wr_o,
    output logic [7:0] wdt_ctl_data_o,
    output logic irq_o
);
    localparam int CW = $clog2(POR_LONG_CYC + 1);
    localparam int BREAK_CYC = BREAK_BITS * BIT_CYC;
    localparam int LW = $clog2(BREAK_CYC + 1);
    localparam int TW = $clog2(BIT_CYC);

    if (POR_SHORT_CYC < 1 || POR_LONG_CYC <= POR_SHORT_CYC || HOLD_CYC < 1
        || HOLD_CYC > POR_LONG_CYC || BIT_CYC < 4) begin : g_check
        $error("rstc_top: unsupported parameter values");
    end

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [2:0] sync_q [3];
    logic [2:0] lvl_q;
    logic [2:0] raw;
    logic pwr_ok;
    logic pin_hi;
    logic line;

    assign raw = {debug_line_i, pin_reset_n_i, power_good_i};
    assign pwr_ok = lvl_q[0];
    assign pin_hi = lvl_q[1];
    assign line = lvl_q[2];

    // A change is taken only when stages two and three agree
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int i = 0; i < 3; i++) begin
                sync_q[i] <= {3{SYNC_RST[i]}};
            end
            lvl_q <= SYNC_RST;
        end else begin
            for (int i = 0; i < 3; i++) begin
                sync_q[i] <= {sync_q[i][1:0], raw[i]};
                if (sync_q[i][1] == sync_q[i][2]) begin
                    lvl_q[i] <= sync_q[i][2];
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Reset pin filter
    // ----------------------------------------------------------------
    logic [2:0] pin_cnt_q;
    logic [2:0] pin_thr;
    logic pin_rst;

    // Stop filter needs a running clock; pulses seen at fewer than two clock edges die in the synchroniser
    assign pin_thr = stop_mode_i ? STOP_FILT_CYC : PIN_FILT_CYC; // [R4] [R5]
    assign pin_rst = (pin_cnt_q >= pin_thr); // [R4] [R5]

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin_cnt_q <= 3'h0;
        end else if (pin_hi) begin
            pin_cnt_q <= 3'h0; // [R17]
        end else if (pin_cnt_q < PIN_FILT_CYC) begin
            pin_cnt_q <= pin_cnt_q + 3'h1; // [R17]
        end
    end

    // ----------------------------------------------------------------
    // Debug line checks
    // ----------------------------------------------------------------
    logic [LW-1:0] low_cnt_q;
    logic line_d_q;
    logic rx_busy_q;
    logic [TW-1:0] rx_tmr_q;
    logic [3:0] rx_idx_q;
    logic [2:0] tx_dly_q;
    logic break_evt;
    logic frame_evt;
    logic coll_evt;
    logic dbg_err;

    assign break_evt = !line && (low_cnt_q == LW'(BREAK_CYC - 1)); // [R10]
    assign frame_evt = rx_busy_q && (rx_tmr_q == '0) && (rx_idx_q == STOP_IDX) && !line; // [R11]
    // Device end released the line high yet it reads low
    assign coll_evt = tx_dly_q[2] && tx_dly_q[1] && !line; // [R12]
    assign dbg_err = break_evt || frame_evt || coll_evt;

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            low_cnt_q <= '0;
        end else if (line) begin
            low_cnt_q <= '0;
        end else if (low_cnt_q < LW'(BREAK_CYC)) begin
            low_cnt_q <= low_cnt_q + LW'(1);
        end
    end

    // Delay matches the transmit bit to the synchroniser latency
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tx_dly_q <= 3'h0;
        end else begin
            tx_dly_q <= {tx_dly_q[1:0], dbg_tx_en_i && dbg_tx_bit_i};
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            line_d_q <= 1'b1;
            rx_busy_q <= 1'b0;
            rx_tmr_q <= '0;
            rx_idx_q <= 4'h0;
        end else begin
            line_d_q <= line;
            if (!rx_busy_q) begin
                if (line_d_q && !line) begin
                    rx_busy_q <= 1'b1;
                    rx_tmr_q <= TW'(BIT_CYC / 2 - 1);
                    rx_idx_q <= 4'h0;
                end
            end else if (rx_tmr_q != '0) begin
                rx_tmr_q <= rx_tmr_q - TW'(1);
            end else begin
                rx_tmr_q <= TW'(BIT_CYC - 1);
                if (rx_idx_q == STOP_IDX || (rx_idx_q == 4'h0 && line)) begin
                    rx_busy_q <= 1'b0;
                end else begin
                    rx_idx_q <= rx_idx_q + 4'h1;
                end
            end
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            debug_reset_o <= 1'b0;
        end else begin
            debug_reset_o <= dbg_err; // [R10] [R11] [R12]
        end
    end

    // ----------------------------------------------------------------
    // Reset sequencer
    // ----------------------------------------------------------------
    rstc_state_t state_q;
    logic [CW-1:0] rst_cnt_q;
    logic [CW-1:0] por_tgt;
    logic dbgc_q;
    logic wdt_rst;
    logic dbg_stop_rst;
    logic sys_req;
    logic por_done;

    assign por_tgt = xtal_en_i ? CW'(POR_LONG_CYC) : CW'(POR_SHORT_CYC); // [R2]
    assign wdt_rst = wdt_timeout_i && wdt_reset_mode_i && !stop_mode_i; // [R3]
    assign dbg_stop_rst = dbg_err && stop_mode_i; // [R13]
    assign sys_req = wdt_rst || pin_rst || dbgc_q || dbg_stop_rst; // [R7]
    assign por_done = (state_q == RSTC_POR) && pwr_ok && (rst_cnt_q == por_tgt - CW'(1));

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q <= RSTC_POR;
            rst_cnt_q <= '0;
            fetch_vector_o <= 1'b0;
        end else begin
            fetch_vector_o <= 1'b0;
            if (!pwr_ok) begin
                state_q <= RSTC_POR; // [R1]
                rst_cnt_q <= '0;
            end else begin
                unique case (state_q)
                    RSTC_POR: begin
                        if (por_done) begin
                            state_q <= RSTC_RUN; // [R1]
                            rst_cnt_q <= '0;
                            fetch_vector_o <= 1'b1; // [R8]
                        end else begin
                            rst_cnt_q <= rst_cnt_q + CW'(1);
                        end
                    end
                    RSTC_HOLD: begin
                        if (sys_req) begin
                            rst_cnt_q <= '0;
                        end else if (rst_cnt_q == CW'(HOLD_CYC - 1)) begin
                            state_q <= RSTC_RUN;
                            rst_cnt_q <= '0;
                            fetch_vector_o <= 1'b1; // [R8]
                        end else begin
                            rst_cnt_q <= rst_cnt_q + CW'(1);
                        end
                    end
                    RSTC_RUN: begin
                        if (sys_req) begin
                            state_q <= RSTC_HOLD; // [R3] [R4] [R13]
                            rst_cnt_q <= '0;
                        end
                    end
                    default: begin
                        state_q <= RSTC_POR;
                        rst_cnt_q <= '0;
                    end
                endcase
            end
        end
    end

    assign sys_rst_n_o = (state_q == RSTC_RUN);
    // Debugger survives every reset except power-on
    assign ocd_rst_n_o = (state_q != RSTC_POR); // [R7] [R13]

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [7:0] cause_q;
    logic [7:0] cause_d;
    logic [3:0] irq_q;
    logic [3:0] mask_q;
    logic [3:0] irq_set;
    logic rd_cause;

    assign rd_cause = re_i && (addr_i == ADDR_CAUSE);
    assign irq_set = {wdt_timeout_i && !wdt_reset_mode_i, coll_evt, frame_evt, break_evt};

    // New causes win over the read clear in the same cycle
    always_comb begin
        cause_d = cause_q;
        if (rd_cause) begin
            cause_d[7:4] = 4'h0; // [R16]
        end
        if (por_done) begin
            cause_d = POR_DONE_CAUSE; // [R9]
        end else if (state_q == RSTC_RUN && sys_req) begin
            cause_d = 8'h00; // [R15]
            cause_d[CAUSE_POR] = dbg_stop_rst; // [R14]
            cause_d[CAUSE_STOP] = stop_mode_i;
            cause_d[CAUSE_WDT] = wdt_rst;
            cause_d[CAUSE_PIN] = pin_rst; // [R6]
            cause_d[CAUSE_DBGCTL] = dbgc_q;
            cause_d[CAUSE_DBGLINE] = dbg_stop_rst;
        end else if (irq_set[IRQ_WDT]) begin
            cause_d[CAUSE_WDT] = 1'b1; // [R15]
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cause_q <= CAUSE_RST;
        end else begin
            cause_q <= cause_d;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            dbgc_q <= 1'b0;
        end else if (state_q == RSTC_HOLD) begin
            dbgc_q <= 1'b0;
        end else if (we_i && addr_i == ADDR_DBGCTL) begin
            dbgc_q <= wdata_i[DBGCTL_RESET]; // [R7]
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_q <= IRQ_RST;
            mask_q <= IRQ_RST;
        end else begin
            if (we_i && addr_i == ADDR_IRQ_STAT) begin
                irq_q <= (irq_q & ~(wdata_i[3:0] & IRQ_W1C_MASK)) | irq_set;
            end else begin
                irq_q <= irq_q | irq_set;
            end
            if (we_i && addr_i == ADDR_IRQ_MASK) begin
                mask_q <= wdata_i[3:0];
            end
        end
    end

    assign irq_o = |(irq_q & mask_q);

    // Cause status is read-only; writes to its address feed watchdog unlock
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wdt_ctl_wr_o <= 1'b0;
            wdt_ctl_data_o <= 8'h00;
        end else begin
            wdt_ctl_wr_o <= we_i && (addr_i == ADDR_CAUSE); // [R18]
            if (we_i && addr_i == ADDR_CAUSE) begin
                wdt_ctl_data_o <= wdata_i; // [R18]
            end
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_o <= 8'h00;
        end else if (re_i) begin
            unique case (addr_i)
                ADDR_CAUSE: rdata_o <= cause_q; // [R16] [R18]
                ADDR_DBGCTL: rdata_o <= {7'h00, dbgc_q};
                ADDR_IRQ_STAT: rdata_o <= {4'h0, irq_q};
                ADDR_IRQ_MASK: rdata_o <= {4'h0, mask_q};
                default: rdata_o <= 8'h00;
            endcase
        end else begin
            rdata_o <= 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_run_req;
        state_q == RSTC_RUN && sys_req && pwr_ok;
    endsequence
    sequence s_hold_entry;
        state_q == RSTC_HOLD && !sys_rst_n_o;
    endsequence

    property p_por_release;
        @(posedge clock_i) disable iff (!arst_n_i)
        $rose(sys_rst_n_o) && $past(state_q) == RSTC_POR |-> $past(rst_cnt_q) == $past(por_tgt) - CW'(1);
    endproperty
    a_por_release: assert property (p_por_release) else $error("early power-on release"); // [R1]

    property p_por_long;
        @(posedge clock_i) disable iff (!arst_n_i)
        $rose(sys_rst_n_o) && $past(state_q) == RSTC_POR && $past(xtal_en_i)
            |-> $past(rst_cnt_q) == CW'(POR_LONG_CYC - 1);
    endproperty
    a_por_long: assert property (p_por_long) else $error("crystal delay not longer"); // [R2]

    property p_wdt_reset;
        @(posedge clock_i) disable iff (!arst_n_i)
        state_q == RSTC_RUN && pwr_ok && wdt_timeout_i && !wdt_reset_mode_i && !pin_rst
            && !dbgc_q && !dbg_err |=> sys_rst_n_o;
    endproperty
    a_wdt_reset: assert property (p_wdt_reset) else $error("watchdog interrupt caused reset"); // [R3]

    property p_pin_filter;
        @(posedge clock_i) disable iff (!arst_n_i)
        pin_rst && !stop_mode_i |-> !$past(pin_hi, 1) && !$past(pin_hi, 2) && !$past(pin_hi, 3)
            && !$past(pin_hi, 4);
    endproperty
    a_pin_filter: assert property (p_pin_filter) else $error("short pin pulse accepted"); // [R4]

    property p_pin_hold;
        @(posedge clock_i) disable iff (!arst_n_i)
        s_run_req and pin_rst |=> s_hold_entry ##0 cause_q[CAUSE_PIN];
    endproperty
    a_pin_hold: assert property (p_pin_hold) else $error("pin reset not taken"); // [R6]

    property p_fetch;
        @(posedge clock_i) disable iff (!arst_n_i)
        $rose(sys_rst_n_o) |-> fetch_vector_o ##1 !fetch_vector_o;
    endproperty
    a_fetch: assert property (p_fetch) else $error("no vector fetch on release"); // [R8]

    property p_por_flag;
        @(posedge clock_i) disable iff (!arst_n_i)
        por_done |=> cause_q == POR_DONE_CAUSE && sys_rst_n_o;
    endproperty
    a_por_flag: assert property (p_por_flag) else $error("power-on flag not set"); // [R9]

    property p_break;
        @(posedge clock_i) disable iff (!arst_n_i)
        break_evt |=> debug_reset_o && irq_q[IRQ_BREAK];
    endproperty
    a_break: assert property (p_break) else $error("break not flagged"); // [R10]

    property p_dbg_stop;
        @(posedge clock_i) disable iff (!arst_n_i)
        s_run_req and dbg_stop_rst |=> s_hold_entry ##0 cause_q[CAUSE_POR] ##0 ocd_rst_n_o;
    endproperty
    a_dbg_stop: assert property (p_dbg_stop) else $error("debug reset in stop mishandled"); // [R13] [R14]

    property p_read_clear;
        @(posedge clock_i) disable iff (!arst_n_i)
        rd_cause && !por_done && !(state_q == RSTC_RUN && sys_req) && !irq_set[IRQ_WDT]
            |=> cause_q[7:4] == 4'h0 && cause_q[3:0] == $past(cause_q[3:0])
            && rdata_o == $past(cause_q);
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("read clear wrong"); // [R16]

    property p_ocd_keep;
        @(posedge clock_i) disable iff (!arst_n_i)
        s_run_req and dbgc_q |=> !sys_rst_n_o && ocd_rst_n_o;
    endproperty
    a_ocd_keep: assert property (p_ocd_keep) else $error("debugger reset by control bit"); // [R7]
endmodule

// ### rstc_partner.sv
// Model of the external reset source and the serial debug host
`timescale 1ns/1ps
module rstc_partner #(
    parameter int BIT_CYC = 4
) (
    input wire logic clock_i,
    output logic pin_reset_n_o,
    output logic debug_line_o
);
    // Both lines have pull-ups, so released means high
    initial begin
        pin_reset_n_o = 1'b1;
        debug_line_o = 1'b1;
    end
    task automatic pin_pulse(input int cyc);
        pin_reset_n_o <= 1'b0;
        repeat (cyc) @(posedge clock_i);
        pin_reset_n_o <= 1'b1;
    endtask
    task automatic send_bit(input logic b);
        debug_line_o <= b;
        repeat (BIT_CYC) @(posedge clock_i);
    endtask
    // Host drives only on command; a collision is made only when asked
    task automatic send_char(input logic [7:0] data, input logic stop);
        send_bit(1'b0);
        for (int i = 0; i < 8; i++) begin
            send_bit(data[i]);
        end
        send_bit(stop);
        send_bit(1'b1);
    endtask
    task automatic send_break();
        repeat (10) send_bit(1'b0);
        send_bit(1'b1);
    endtask
endmodule

// ### rstc_top_tb.sv
// Self-checking bench for the system reset controller
`timescale 1ns/1ps
module rstc_top_tb import rstc_pkg::*; ;
    localparam int PS = 4;
    localparam int PL = 8;
    logic clock_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic power_good_i, xtal_en_i, stop_mode_i, dbg_tx_en_i, dbg_tx_bit_i;
    logic wdt_timeout_i, wdt_reset_mode_i, we_i, re_i, sys_prev;
    logic [7:0] addr_i, wdata_i, rdata_o, wdt_ctl_data_o, rd, rnd, c;
    logic pin_reset_n_i, debug_line_i, sys_rst_n_o, ocd_rst_n_o, fetch_vector_o;
    logic debug_reset_o, wdt_ctl_wr_o, irq_o;
    int fail_count = 0, comparisons = 0, dbg_pulses = 0, rst_falls = 0, ocd_lows = 0;
    int n, n_short, n_long, f0, o0, d0;
    int pw[3] = '{3, 6, 2};
    logic [7:0] wr_q[$];
    always #12.5 clock_i = ~clock_i;
    rstc_top #(.POR_SHORT_CYC(PS), .POR_LONG_CYC(PL), .HOLD_CYC(2), .BIT_CYC(4)) DUT (
        .clock_i(clock_i), .arst_n_i(arst_n_i), .power_good_i(power_good_i),
        .xtal_en_i(xtal_en_i), .stop_mode_i(stop_mode_i), .pin_reset_n_i(pin_reset_n_i),
        .debug_line_i(debug_line_i), .dbg_tx_en_i(dbg_tx_en_i), .dbg_tx_bit_i(dbg_tx_bit_i),
        .wdt_timeout_i(wdt_timeout_i), .wdt_reset_mode_i(wdt_reset_mode_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o),
        .sys_rst_n_o(sys_rst_n_o), .ocd_rst_n_o(ocd_rst_n_o), .fetch_vector_o(fetch_vector_o),
        .debug_reset_o(debug_reset_o), .wdt_ctl_wr_o(wdt_ctl_wr_o),
        .wdt_ctl_data_o(wdt_ctl_data_o), .irq_o(irq_o));
    rstc_partner #(.BIT_CYC(4)) P (.clock_i(clock_i), .pin_reset_n_o(pin_reset_n_i),
        .debug_line_o(debug_line_i));
    // ----------------------------------------------------------------
    // Checking helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    always @(posedge clock_i) begin
        sys_prev <= sys_rst_n_o;
        if (sys_rst_n_o === 1'b0 && sys_prev === 1'b1) rst_falls++;
        if (ocd_rst_n_o === 1'b0) ocd_lows++;
        if (debug_reset_o === 1'b1) dbg_pulses++;
        if (wdt_ctl_wr_o === 1'b1) chk(wdt_ctl_data_o, (wr_q.size() > 0) ? wr_q.pop_front() : 8'hxx);
    end
    task automatic idle(input int cyc);
        repeat (cyc) @(posedge clock_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        we_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        idle(1);
        we_i <= 1'b0;
        idle(1);
    endtask
    task automatic rdr(input logic [7:0] a);
        re_i <= 1'b1;
        addr_i <= a;
        idle(1);
        re_i <= 1'b0;
        #1 rd = rdata_o;
        idle(1);
    endtask
    // Bounded wait for the system reset output to reach a level
    task automatic wait_sys(input logic lvl, output int cnt);
        cnt = 0;
        #1;
        while (sys_rst_n_o !== lvl) begin
            idle(1);
            #1;
            cnt++;
            if (cnt > 300) begin
                fail_count++;
                $display("Error at %0t: reset output wait timed out", $time);
                conclude();
            end
        end
        if (lvl) chk({7'h00, fetch_vector_o}, {7'h00, cnt > 0});
        idle(1);
    endtask
    // Debugger keeps running through every system reset after power-on
    task automatic after_src(input logic nf, input logic [7:0] m);
        idle(12);
        wait_sys(1'b1, n);
        chk({7'h00, rst_falls > f0}, {7'h00, nf});
        chk(8'(ocd_lows - o0), 8'h00);
        rdr(ADDR_CAUSE);
        chk(rd & m, m);
        f0 = rst_falls;
        o0 = ocd_lows;
    endtask
    task automatic wdt_pulse(input logic mode);
        wdt_reset_mode_i <= mode;
        wdt_timeout_i <= 1'b1;
        idle(1);
        wdt_timeout_i <= 1'b0;
    endtask
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {power_good_i, xtal_en_i, stop_mode_i, dbg_tx_en_i} <= 4'h8;
        {dbg_tx_bit_i, wdt_timeout_i, wdt_reset_mode_i, we_i, re_i} <= 5'h10;
        {addr_i, wdata_i} <= 16'h0000;
        rnd = 8'($urandom(79));
        idle(20);
        arst_n_i <= 1'b1;
        wait_sys(1'b1, n);
        chk({7'h00, ocd_rst_n_o}, 8'h01);
        rdr(ADDR_CAUSE);
        chk(rd, POR_DONE_CAUSE);
        rdr(ADDR_CAUSE);
        chk(rd, 8'h00);
        for (int x = 0; x < 2; x++) begin
            xtal_en_i <= x[0];
            power_good_i <= 1'b0;
            wait_sys(1'b0, n);
            chk({7'h00, ocd_rst_n_o}, 8'h00);
            idle(4);
            power_good_i <= 1'b1;
            wait_sys(1'b1, n);
            if (x == 0) n_short = n;
            else n_long = n;
        end
        chk(8'(n_long - n_short), 8'(PL - PS));
        chk({7'h00, n_short >= PS}, 8'h01);
        f0 = rst_falls;
        o0 = ocd_lows;
        for (int k = 0; k < 3; k++) begin
            stop_mode_i <= (k == 2);
            idle(1);
            P.pin_pulse(pw[k]);
            after_src(k > 0, (k > 0) ? 8'h10 : 8'h00);
        end
        stop_mode_i <= 1'b0;
        wr(ADDR_DBGCTL, 8'h01);
        after_src(1'b1, 8'h08);
        wdt_pulse(1'b1);
        after_src(1'b1, 8'h20);
        wdt_pulse(1'b0);
        after_src(1'b0, 8'h20);
        rdr(ADDR_IRQ_STAT);
        chk(rd & 8'h08, 8'h08);
        chk({7'h00, irq_o}, 8'h00);
        wr(ADDR_IRQ_MASK, 8'h08);
        chk({7'h00, irq_o}, 8'h01);
        wr(ADDR_IRQ_STAT, 8'h08);
        chk({7'h00, irq_o}, 8'h00);
        for (int k = 0; k < 3; k++) begin
            stop_mode_i <= (k == 2);
            d0 = dbg_pulses;
            if (k == 0) P.send_char(rnd, 1'b0);
            else if (k == 1) begin
                dbg_tx_en_i <= 1'b1;
                idle(6);
                P.send_bit(1'b0);
                P.send_bit(1'b1);
                dbg_tx_en_i <= 1'b0;
            end else P.send_break();
            after_src(k == 2, (k == 2) ? 8'h80 : 8'h00);
            chk({7'h00, dbg_pulses > d0}, 8'h01);
            rdr(ADDR_IRQ_STAT);
            if (k < 2) chk(rd & (8'h02 << k), 8'h02 << k);
            wr(ADDR_IRQ_STAT, 8'h0f);
        end
        stop_mode_i <= 1'b0;
        for (int k = 0; k < 2; k++) begin
            rdr(ADDR_CAUSE);
            c = rd;
            rnd = 8'($urandom());
            wr_q.push_back(rnd);
            wr(ADDR_CAUSE, rnd);
            rdr(ADDR_CAUSE);
            chk(rd, c & 8'h0f);
        end
        chk(8'(wr_q.size()), 8'h00);
        wr(8'h07, 8'hff);
        rdr(8'h07);
        chk(rd, 8'h00);
        conclude();
    end
endmodule
